/* core/byte_downcounter.sv */
// Purpose: Buffer byte down-counter with load and zero-reach pulse.
// Assumes: Decrement is one byte per serviced beat.
// Notes:   Zero pulse fires once on the step that reaches zero.
`timescale 1ns/1ps
module byte_downcounter #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             step,
  output logic      [WIDTH-1:0] count,
  output logic                  reached_zero
);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count        <= '0;
      reached_zero <= 1'b0;
    end else if (load) begin
      count        <= load_value;
      reached_zero <= 1'b0;
    end else if (step && count != '0) begin
      count        <= count - WIDTH'(1);
      reached_zero <= (count == WIDTH'(1));
    end else begin
      reached_zero <= 1'b0;
    end
  end

endmodule : byte_downcounter

/* core/dma_channel_status.sv */
// Purpose: Status tracking and control for one USB device DMA channel.
// Assumes: Endpoint, FIFO and descriptor signals are on core_clk; no synchronisers needed.
// Notes:   Registers reached over Avalon-MM; read answered one cycle after request.
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
module dma_channel_status
  import dma_status_pkg::*;
#(
  parameter int CNT_W = COUNT_W
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // Avalon-MM slave
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  // Endpoint side
  input  wire logic         ep_request,
  input  wire logic         ep_priority_win,
  input  wire logic         ep_packet_done,
  input  wire logic         ep_transfer_end,
  input  wire logic         fifo_empty,
  // Descriptor load; beat and interrupt outputs
  input  wire logic         dsc_valid,
  input  wire descriptor_t  dsc_data,
  output logic              dsc_fetch,
  output logic              xfer_beat,
  output logic              irq
);

  chan_state_t      state;
  logic             ctrl_enable;
  logic             ctrl_load_next;
  logic             chan_enb;
  logic             chan_act;
  logic             bf_cut;
  logic [CNT_W-1:0] count;
  logic             count_zero;
  logic             bf_end_flag;
  logic             tr_end_flag;
  logic [2:0]       irq_stat;
  logic [2:0]       irq_mask;
  logic             next_beat;
  logic             wr_ctrl;
  logic             rd_status;
  logic             wr_irq_stat;
  logic             end_by_usb;
  logic             xfer_end;
  logic             dsc_taken;
  logic [2:0]       irq_event;
  logic             ctrl_low_we;

  // Single-cycle wait: each request is answered at the edge after it rises
  assign wr_ctrl     = avs_write && !avs_waitrequest && avs_address == OFS_CONTROL;
  assign ctrl_low_we = avs_byteenable[0];
  assign rd_status   = avs_read && !avs_waitrequest && avs_address == OFS_STATUS;
  assign wr_irq_stat = avs_write && !avs_waitrequest && avs_address == OFS_IRQ_STAT
                       && avs_byteenable[0];
  assign end_by_usb  = ep_transfer_end && ep_packet_done && state == ST_XFER;
  assign xfer_end    = end_by_usb || (count_zero && state == ST_XFER);
  assign dsc_taken   = dsc_valid && state == ST_LOAD;
  assign next_beat   = state == ST_XFER && chan_enb && ep_request && count != '0;

  // Waitrequest is high in the idle cycle so every access takes exactly one wait state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      avs_readdata <= UNMAPPED_DATA;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        OFS_CONTROL: begin
          avs_readdata <= {30'h0, ctrl_load_next, ctrl_enable};
        end
        OFS_STATUS: begin
          avs_readdata <= {26'h0, bf_end_flag, tr_end_flag, 2'b00, chan_act, chan_enb};
        end
        OFS_COUNT: begin
          avs_readdata <= 32'(count);
        end
        OFS_IRQ_STAT: begin
          avs_readdata <= {29'h0, irq_stat};
        end
        OFS_IRQ_MASK: begin
          avs_readdata <= {29'h0, irq_mask};
        end
        default: begin
          avs_readdata <= UNMAPPED_DATA;
        end
      endcase
    end
  end

  // Control bits: software writes or descriptor load, descriptor wins on a collision
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_enable    <= RESET_CONTROL[BIT_ENABLE];
      ctrl_load_next <= RESET_CONTROL[BIT_LOAD_NEXT];
    end else if (dsc_taken) begin
      ctrl_enable    <= dsc_data.enable;
      ctrl_load_next <= dsc_data.load_next;
    end else if (wr_ctrl && ctrl_low_we) begin
      ctrl_enable    <= avs_writedata[BIT_ENABLE];
      ctrl_load_next <= avs_writedata[BIT_LOAD_NEXT];
    end else if (xfer_end) begin
      ctrl_enable    <= 1'b0;
    end
  end

  // Channel sequencing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (ctrl_enable) begin
            state <= ST_XFER;
          end else if (ctrl_load_next) begin
            state <= ST_LOAD;
          end
        end
        ST_XFER: begin
          if (xfer_end) begin
            state <= ctrl_load_next ? ST_LOAD : ST_IDLE;
          end else if (!ctrl_enable) begin
            state <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (fifo_empty) begin
            state <= ctrl_load_next ? ST_LOAD : ST_IDLE;
          end
        end
        ST_LOAD: begin
          if (dsc_valid) begin
            state <= dsc_data.enable ? ST_XFER : ST_IDLE;
          end
        end
      endcase
    end
  end

  // Enable status mirrors the running state; it drops at once on a transfer end, but after drain on a disable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      chan_enb <= 1'b0;
    end else if (state == ST_XFER && xfer_end) begin
      chan_enb <= 1'b0;
    end else if (state == ST_DRAIN) begin
      chan_enb <= !fifo_empty;
    end else if (dsc_taken) begin
      chan_enb <= dsc_data.enable;
    end else if (state == ST_IDLE) begin
      chan_enb <= ctrl_enable;
    end
  end

  // A buffer-end cut keeps the channel active across the next descriptor load
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bf_cut <= 1'b0;
    end else if (state == ST_XFER && count_zero && !ep_packet_done) begin
      bf_cut <= 1'b1;
    end else if (ep_packet_done || (state == ST_IDLE && !ctrl_load_next)) begin
      bf_cut <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      chan_act <= 1'b0;
    end else if (ep_packet_done) begin
      chan_act <= 1'b0;
    end else if (bf_cut && (state == ST_LOAD || state == ST_XFER)) begin
      chan_act <= 1'b1;
    end else begin
      chan_act <= state == ST_XFER && chan_enb && ep_request && ep_priority_win;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      xfer_beat <= 1'b0;
      dsc_fetch <= 1'b0;
    end else begin
      xfer_beat <= next_beat;
      dsc_fetch <= state == ST_LOAD && !dsc_valid;
    end
  end

  byte_downcounter #(
    .WIDTH (CNT_W)
  ) u_count (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .load         (dsc_taken),
    .load_value   (CNT_W'(dsc_data.count)),
    .step         (next_beat),
    .count        (count),
    .reached_zero (count_zero)
  );

  // Flags persist until read; status writes are ignored entirely
  sticky_flag u_bf_end (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .set      (count_zero),
    .clear    (rd_status),
    .flag     (bf_end_flag)
  );

  sticky_flag u_tr_end (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .set      (end_by_usb),
    .clear    (rd_status),
    .flag     (tr_end_flag)
  );

  assign irq_event = {dsc_taken, end_by_usb, count_zero};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_irq
      sticky_flag u_irq (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .set      (irq_event[gi]),
        .clear    (wr_irq_stat && avs_writedata[gi]),
        .flag     (irq_stat[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_mask <= RESET_MASK;
    end else if (avs_write && !avs_waitrequest && avs_address == OFS_IRQ_MASK
                 && avs_byteenable[0]) begin
      irq_mask <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule : dma_channel_status

/* core/dma_status_pkg.sv */
// Purpose: Shared constants and types for the USB device DMA channel status block.
// Assumes: Avalon-MM register slave with 32-bit data and byte addresses.
// Notes:   Register offsets are chosen locally; status bit positions follow the channel layout.
package dma_status_pkg;

  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_COUNT     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

  localparam int BIT_ENABLE    = 0;
  localparam int BIT_LOAD_NEXT = 1;

  localparam int BIT_CHAN_ENB  = 0;
  localparam int BIT_CHAN_ACT  = 1;
  localparam int BIT_TR_END    = 4;
  localparam int BIT_BF_END    = 5;

  localparam int BIT_IRQ_BF    = 0;
  localparam int BIT_IRQ_TR    = 1;
  localparam int BIT_IRQ_DSC   = 2;

  localparam int          COUNT_W       = 16;
  localparam logic [31:0] RESET_CONTROL = 32'h0000_0000;
  localparam logic [2:0]  RESET_MASK    = 3'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic        enable;
    logic        load_next;
    logic [15:0] count;
  } descriptor_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_XFER  = 2'b01,
    ST_DRAIN = 2'b11,
    ST_LOAD  = 2'b10
  } chan_state_t;

endpackage : dma_status_pkg

/* core/sticky_flag.sv */
// Purpose: One sticky event flag with clear request; set wins over clear.
// Assumes: Set and clear come from core_clk logic.
// Notes:   Used for end flags and interrupt status bits.
`timescale 1ns/1ps
module sticky_flag (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule : sticky_flag

/* verification/dma_status_assertions.sv */
// Purpose: Port-level checks of the DMA channel status block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module dma_status_checker
  import dma_status_pkg::*;
#(
  parameter int CNT_W = COUNT_W
) (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ep_request,
  input wire logic        ep_priority_win,
  input wire logic        ep_packet_done,
  input wire logic        ep_transfer_end,
  input wire logic        fifo_empty,
  input wire logic        dsc_valid,
  input wire descriptor_t dsc_data,
  input wire logic        dsc_fetch,
  input wire logic        xfer_beat,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic req;
  assign req = avs_read || avs_write;
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_ans; req && avs_waitrequest |-> ##[1:2] !avs_waitrequest; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_wait_cause; !avs_waitrequest |-> $past(req); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_rd_stable;
    avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata);
  endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  property p_beat_req; xfer_beat |-> $past(ep_request); endproperty
  a_beat_req: assert property (p_beat_req) else $error("beat without request");
  property p_fetch_hold; dsc_fetch && !dsc_valid |=> dsc_fetch; endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped early");
  property p_load_idle; dsc_fetch && $past(dsc_fetch) |-> !xfer_beat; endproperty
  a_load_idle: assert property (p_load_idle) else $error("beat while loading");
  property p_st_rsvd;
    avs_read && !avs_waitrequest && avs_address == OFS_STATUS
      |-> avs_readdata[31:6] == 26'h0 && avs_readdata[3:2] == 2'h0;
  endproperty
  a_st_rsvd: assert property (p_st_rsvd) else $error("status spare bits set");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > OFS_IRQ_MASK |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_desc: cover property (dsc_valid);
  c_beat: cover property (xfer_beat);
  c_irq: cover property ($rose(irq));
endmodule : dma_status_checker

bind dma_channel_status dma_status_checker #(.CNT_W(CNT_W)) chk_i (
  .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ep_request(ep_request),
  .ep_priority_win(ep_priority_win), .ep_packet_done(ep_packet_done),
  .ep_transfer_end(ep_transfer_end), .fifo_empty(fifo_empty), .dsc_valid(dsc_valid),
  .dsc_data(dsc_data), .dsc_fetch(dsc_fetch), .xfer_beat(xfer_beat), .irq(irq));

/* verification/ep_partner.sv */
// Purpose: Endpoint, FIFO and descriptor source facing one DMA channel.
// Assumes: All signals on core_clk; descriptor answered after DLY idle cycles.
// Notes:   Released descriptor bus shows the inverse, not the last value.
`timescale 1ns/1ps
module ep_partner
  import dma_status_pkg::*;
#(
  parameter int DLY = 2
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         dsc_fetch,
  input  wire logic         xfer_beat,
  input  wire descriptor_t  next_dsc,
  input  wire logic         req_on,
  input  wire logic         fifo_hold,
  output logic              ep_request,
  output logic              ep_priority_win,
  output logic              dsc_valid,
  output descriptor_t       dsc_data,
  output logic              fifo_empty
);
  int cnt;
  assign ep_priority_win = ep_request;
  assign dsc_data        = dsc_valid ? next_dsc : descriptor_t'(~next_dsc);
  always @(posedge core_clk) begin
    ep_request <= reset_n && req_on;
    // Data stays in the FIFO while held, so a disable must wait for it
    fifo_empty <= !reset_n || !(xfer_beat || fifo_hold);
    dsc_valid  <= 1'b0;
    if (!reset_n || !dsc_fetch || dsc_valid) begin
      cnt <= 0;
    end else if (cnt == DLY) begin
      dsc_valid <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ep_partner

/* verification/testbench.sv */
// Purpose: Register-level tests of the DMA channel status block.
// Assumes: Avalon answer comes after one wait state; partner supplies descriptors.
// Notes:   Polls interrupt status, since status reads clear the end flags.
`timescale 1ns/1ps
module testbench
  import dma_status_pkg::*;
;
  logic core_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, ep_request, ep_priority_win, fifo_empty, dsc_valid;
  logic ep_packet_done = 0, ep_transfer_end = 0, req_on = 0, fifo_hold = 0;
  logic dsc_fetch, xfer_beat, irq;
  descriptor_t dsc_data, nd = '0;
  int num_errors = 0, n_checks = 0, beats = 0, b;
  logic [7:0] rst_a [6] = '{OFS_CONTROL, OFS_STATUS, OFS_COUNT, OFS_IRQ_STAT,
                            OFS_IRQ_MASK, 8'h20};
  always #2 core_clk = ~core_clk;
  dma_channel_status dma_channel_status_i (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ep_request(ep_request),
    .ep_priority_win(ep_priority_win), .ep_packet_done(ep_packet_done),
    .ep_transfer_end(ep_transfer_end), .fifo_empty(fifo_empty), .dsc_valid(dsc_valid),
    .dsc_data(dsc_data), .dsc_fetch(dsc_fetch), .xfer_beat(xfer_beat), .irq(irq));
  ep_partner ep_partner_i (.core_clk(core_clk), .reset_n(reset_n), .dsc_fetch(dsc_fetch),
    .xfer_beat(xfer_beat), .next_dsc(nd), .req_on(req_on), .fifo_hold(fifo_hold),
    .ep_request(ep_request), .ep_priority_win(ep_priority_win), .dsc_valid(dsc_valid),
    .dsc_data(dsc_data), .fifo_empty(fifo_empty));
  always @(posedge core_clk) if (xfer_beat === 1'b1) beats <= beats + 1;

  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Polls interrupt status until the given bit is set
  task automatic wait_irq(input int bit_i);
    int n;
    n = 0;
    do begin
      bus(0, OFS_IRQ_STAT, 0);
      n++;
    end while (q[bit_i] !== 1'b1 && n < 200);
    chk("irq_stat", q[bit_i], 1'b1);
  endtask : wait_irq

  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    req_on  <= 1'b1;
    foreach (rst_a[i]) begin
      bus(0, rst_a[i], 0);
      chk("reset_value", q, 32'h0);
    end
    bus(1, OFS_STATUS, 32'hffff_ffff);
    bus(0, OFS_STATUS, 0);
    chk("status_ro", q, 32'h0);
    nd <= {1'b1, 1'b0, 16'h0003};
    bus(1, OFS_IRQ_MASK, 32'h7);
    // Load-next only: the byte count comes from a descriptor, so start by fetching one
    bus(1, OFS_CONTROL, 32'h2);
    wait_irq(BIT_IRQ_BF);
    chk("beats", beats, 3);
    bus(0, OFS_STATUS, 0);
    chk("status_bf_end", q, 32'h20);
    bus(0, OFS_STATUS, 0);
    chk("status_cleared", q, 32'h0);
    chk("irq_set", irq, 1'b1);
    bus(1, OFS_IRQ_STAT, 32'h7);
    bus(0, OFS_IRQ_STAT, 0);
    chk("irq_stat_w1c", q, 32'h0);
    chk("irq_clear", irq, 1'b0);
    nd <= {1'b1, 1'b0, 16'd100};
    bus(1, OFS_CONTROL, 32'h2);
    repeat (12) @(posedge core_clk);
    ep_packet_done  <= 1'b1;
    ep_transfer_end <= 1'b1;
    @(posedge core_clk);
    ep_packet_done  <= 1'b0;
    ep_transfer_end <= 1'b0;
    wait_irq(BIT_IRQ_TR);
    bus(0, OFS_STATUS, 0);
    chk("status_tr_end", q, 32'h10);
    fifo_hold <= 1'b1;
    bus(1, OFS_CONTROL, 32'h3);
    repeat (12) @(posedge core_clk);
    bus(0, OFS_STATUS, 0);
    chk("active_enabled", q[1:0], 2'b11);
    bus(1, OFS_CONTROL, 32'h0);
    bus(0, OFS_STATUS, 0);
    chk("enable_while_drain", q[0], 1'b1);
    fifo_hold <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus(0, OFS_STATUS, 0);
    chk("enable_after_drain", q[0], 1'b0);
    b = beats;
    repeat (6) @(posedge core_clk);
    chk("beats_stopped", beats, b);
    results();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results();
  end
endmodule : testbench
